// *** clock_monitor_pkg.sv ***
package clock_monitor_pkg;
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_TRIM = 4'h8;
	localparam logic [3:0] OFS_FLAGS = 4'hC;
	localparam logic [7:0] CONTROL_RESET = 8'h38;
	localparam logic [3:0] FREQ_RESET = 4'h7;
	localparam logic [3:0] FREQ_PLL_CODE = 4'hE;
	localparam int BIT_SOFT_PLL = 7;
	localparam int BIT_SEC_READY = 7;
	localparam int BIT_PLL_READY = 6;
	localparam int BIT_EXT_RUNNING = 5;
	localparam int BIT_HF_READY = 4;
	localparam int BIT_HF_LOCKED = 3;
	localparam int BIT_MF_READY = 2;
	localparam int BIT_LF_READY = 1;
	localparam int BIT_HF_STABLE = 0;
	localparam int SAMPLE_DIV = 64;
	localparam logic [10:0] START_COUNT = 11'h400;
	localparam logic [2:0] MODE_LP = 3'h0;
	localparam logic [2:0] MODE_XT = 3'h1;
	localparam logic [2:0] MODE_HS = 3'h2;
	localparam logic [1:0] SEL_CONFIG = 2'h0;
	localparam logic [1:0] SEL_SECONDARY = 2'h1;
	typedef enum logic [1:0] {
		CLK_CONFIG = 2'b00,
		CLK_SECONDARY = 2'b01,
		CLK_INTERNAL = 2'b10
	} clk_source_t;
	typedef struct packed {
		logic pll_ready;
		logic hf_ready;
		logic hf_locked;
		logic mf_ready;
		logic lf_ready;
		logic hf_stable;
		logic sec_ready;
	} osc_ready_t;
	typedef struct packed {
		logic [2:0] config_oscillator_mode;
		logic fail_monitor_config_enable;
		logic config_pll_force;
	} config_word_t;
endpackage

// *** fail_safe_clock_monitor.sv ***
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fail_safe_clock_monitor
	import clock_monitor_pkg::*;
(
	// System clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Oscillator side.
	input wire logic ext_clk_i,
	input wire logic lf_osc_clk_i,
	input wire logic ext_start_tick_i,
	input wire logic sleep_i,
	input wire logic secondary_osc_enable_i,
	input wire clock_monitor_pkg::osc_ready_t ready_i,
	input wire clock_monitor_pkg::config_word_t config_i,
	// Clock control outputs.
	output clock_monitor_pkg::clk_source_t clk_source_o,
	output logic [3:0] internal_freq_o,
	output logic pll_enable_o,
	output logic [5:0] freq_trim_o,
	output logic osc_fail_flag_o
);
	import clock_monitor_pkg::*;

	// Low-frequency edges in one sample half-period, less one.
	localparam logic [4:0] HALF_DIV = 5'(SAMPLE_DIV / 2 - 1);
	logic [7:0] control_reg;
	logic [5:0] trim_reg;
	logic fail_reg;
	logic flag_reg;
	logic [10:0] start_reg;
	logic ext_running_reg;
	logic [2:0] ext_sync_reg;
	logic [2:0] lf_sync_reg;
	logic [5:0] div_reg;
	logic sample_reg;
	logic sample_prev_reg;
	logic latch_reg;
	logic [7:0] status_reg;
	logic monitor_active;
	logic ext_fall;
	logic sample_rise;
	logic lf_rise;
	logic bus_req;
	logic bus_write;
	logic select_change;
	logic fail_event;
	logic uses_timer;
	logic [7:0] read_mux;

	// Only crystal modes need the start timer; clock input and RC modes are ready at once.
	function automatic logic crystal_mode(input logic [2:0] m);
		crystal_mode = (m == MODE_LP) || (m == MODE_XT) || (m == MODE_HS);
	endfunction

	assign uses_timer = crystal_mode(config_i.config_oscillator_mode);
	assign bus_req = cyc_i && stb_i && !ack_o;
	assign bus_write = bus_req && we_i && sel_i[0];
	assign select_change = bus_write && (adr_i == OFS_CONTROL)
		&& (dat_i[1:0] != control_reg[1:0]);

	// Asynchronous clocks pass two flip-flops; the third stage only serves edge detection.
	always_ff @(posedge clk_i)
	begin
		ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_i};
		lf_sync_reg <= {lf_sync_reg[1:0], lf_osc_clk_i};
	end

	assign ext_fall = ext_sync_reg[2] && !ext_sync_reg[1];
	assign lf_rise = lf_sync_reg[1] && !lf_sync_reg[2];

	// Sample clock toggles every 32 low-frequency edges, a division by 64.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			div_reg <= 6'h00;
			sample_reg <= 1'b0;
			sample_prev_reg <= 1'b0;
		end
		else
		begin
			sample_prev_reg <= sample_reg;
			if (lf_rise)
			begin
				div_reg <= div_reg + 6'h01;
				if (div_reg[4:0] == HALF_DIV)
					sample_reg <= ~sample_reg;
			end
		end
	end

	assign sample_rise = sample_reg && !sample_prev_reg;

	// Monitor only after start-up has finished, never during it.
	assign monitor_active = config_i.fail_monitor_config_enable && ext_running_reg
		&& !sleep_i;

	// The latch sees falling edges of the external clock; a rising sample edge clears it, the falling sample edge checks it.
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !monitor_active)
			latch_reg <= 1'b1;
		else if (ext_fall)
			latch_reg <= 1'b1;
		else if (sample_rise)
			latch_reg <= 1'b0;
	end

	// Half a sample period after the rising edge cleared it, a still clear latch is a failure.
	assign fail_event = monitor_active && !sample_reg && sample_prev_reg
		&& !latch_reg && !ext_fall;

	// Start timer counts external ticks; mode without timer is ready at once.
	always_ff @(posedge clk_i)
	begin
		if (rst_i || sleep_i || select_change)
		begin
			start_reg <= 11'h000;
			ext_running_reg <= 1'b0;
		end
		else if (control_reg[1:0] != SEL_CONFIG || fail_reg)
			ext_running_reg <= 1'b0;
		else if (!uses_timer)
			ext_running_reg <= 1'b1;
		else if (start_reg == START_COUNT)
			ext_running_reg <= 1'b1;
		else if (ext_start_tick_i)
			start_reg <= start_reg + 11'h001;
	end

	// Fail condition holds until reset, sleep or a change of the clock select.
	always_ff @(posedge clk_i)
	begin
		if (rst_i || sleep_i || select_change)
			fail_reg <= 1'b0;
		else if (fail_event)
			fail_reg <= 1'b1;
	end

	// Fail flag: hardware set wins over a software clear in the same cycle.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flag_reg <= 1'b0;
		else if (fail_event)
			flag_reg <= 1'b1;
		else if (bus_write && adr_i == OFS_FLAGS && !dat_i[0])
			flag_reg <= 1'b0;
	end

	// Control and trim registers; reserved bits are never stored.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			control_reg <= CONTROL_RESET;
			trim_reg <= 6'h00;
		end
		else if (bus_write)
		begin
			if (adr_i == OFS_CONTROL)
				control_reg <= {dat_i[7:3], 1'b0, dat_i[1:0]};
			if (adr_i == OFS_TRIM)
				trim_reg <= dat_i[5:0];
		end
	end

	// Status: secondary ready forced high while its oscillator is off.
	always_comb
	begin
		status_reg = 8'h00;
		status_reg[BIT_SEC_READY] = secondary_osc_enable_i ? ready_i.sec_ready : 1'b1;
		status_reg[BIT_PLL_READY] = ready_i.pll_ready;
		status_reg[BIT_EXT_RUNNING] = ext_running_reg && !fail_reg;
		status_reg[BIT_HF_READY] = ready_i.hf_ready;
		status_reg[BIT_HF_LOCKED] = ready_i.hf_locked;
		status_reg[BIT_MF_READY] = ready_i.mf_ready;
		status_reg[BIT_LF_READY] = ready_i.lf_ready;
		status_reg[BIT_HF_STABLE] = ready_i.hf_stable;
	end

	always_comb
	begin
		unique case (adr_i)
			OFS_CONTROL: read_mux = control_reg;
			OFS_STATUS: read_mux = status_reg;
			OFS_TRIM: read_mux = {2'b00, trim_reg};
			OFS_FLAGS: read_mux = {7'h00, flag_reg};
			default: read_mux = 8'h00;
		endcase
	end

	// Single-wait answer: ack one cycle after the request, then drops.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= bus_req;
			dat_o <= {24'h000000, read_mux};
		end
	end

	// Clock steering; fallback to internal uses the live frequency select.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			clk_source_o <= CLK_INTERNAL;
			internal_freq_o <= FREQ_RESET;
			pll_enable_o <= 1'b0;
			freq_trim_o <= 6'h00;
			osc_fail_flag_o <= 1'b0;
		end
		else
		begin
			internal_freq_o <= control_reg[6:3];
			pll_enable_o <= config_i.config_pll_force || control_reg[BIT_SOFT_PLL];
			freq_trim_o <= trim_reg;
			osc_fail_flag_o <= flag_reg;
			if (control_reg[1])
				clk_source_o <= CLK_INTERNAL;
			else if (control_reg[1:0] == SEL_SECONDARY)
				clk_source_o <= CLK_SECONDARY;
			else if (fail_reg || !ext_running_reg)
				clk_source_o <= CLK_INTERNAL;
			else
				clk_source_o <= CLK_CONFIG;
		end
	end

	// A failure lands in condition and flag, unless a select change clears it at once.
	AST_FAIL_SETS_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
		fail_event && !select_change |=> flag_reg && fail_reg)
		else $error("fail not flagged");

	// While failed on the configured source the clock must stay internal.
	AST_FAIL_INTERNAL: assert property (@(posedge clk_i) disable iff (rst_i)
		fail_reg && control_reg[1:0] == SEL_CONFIG && !select_change
		|=> clk_source_o == CLK_INTERNAL) else $error("no fallback");

	// Only a bus write may take the flag down.
	AST_FLAG_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
		flag_reg && !bus_write |=> flag_reg)
		else $error("flag lost");

	// With the configuration enable clear no failure is ever declared.
	AST_NO_MON_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		!config_i.fail_monitor_config_enable |-> !fail_event)
		else $error("monitor off");

	// A select change drops the fail condition and restarts the timer.
	AST_SEL_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
		select_change |=> !fail_reg && !ext_running_reg)
		else $error("select clear");

	// A failed source never reports itself as running.
	AST_STATUS_EXT: assert property (@(posedge clk_i) disable iff (rst_i)
		fail_reg |-> !status_reg[BIT_EXT_RUNNING])
		else $error("status bit");

	// Secondary ready reads high while that oscillator is off.
	AST_SEC_READY: assert property (@(posedge clk_i) disable iff (rst_i)
		!secondary_osc_enable_i |-> status_reg[BIT_SEC_READY])
		else $error("sec ready");

	// The configuration PLL bit overrides software.
	AST_PLL_FORCE: assert property (@(posedge clk_i) disable iff (rst_i)
		config_i.config_pll_force |=> pll_enable_o)
		else $error("pll force");

	// The bus answer is a single-cycle pulse.
	AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack long");

	// An external falling edge always leaves the latch set.
	AST_LATCH_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		monitor_active && ext_fall |=> latch_reg)
		else $error("latch not set");

	// A rising sample edge with no external fall clears the latch.
	AST_LATCH_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
		monitor_active && sample_rise && !ext_fall |=> !latch_reg)
		else $error("latch not cleared");

	// The sample clock flips once per half of the division.
	AST_SAMPLE_TOGGLE: assert property (@(posedge clk_i) disable iff (rst_i)
		lf_rise && div_reg[4:0] == HALF_DIV |=> sample_reg != $past(sample_reg))
		else $error("sample no toggle");

	// Without a low-frequency edge the sample clock stands still.
	AST_SAMPLE_STILL: assert property (@(posedge clk_i) disable iff (rst_i)
		!lf_rise |=> sample_reg == $past(sample_reg))
		else $error("sample moved");

	// Failures are only declared on a falling sample edge with a clear latch.
	AST_FAIL_AT_HALF: assert property (@(posedge clk_i) disable iff (rst_i)
		fail_event |-> !sample_reg && sample_prev_reg && !latch_reg)
		else $error("fail off edge");

	// Nothing is detected while the oscillator is still starting.
	AST_NO_FAIL_START: assert property (@(posedge clk_i) disable iff (rst_i)
		!ext_running_reg |-> !fail_event)
		else $error("fail in start-up");

	// Sleep drops the fail condition and the running state.
	AST_SLEEP_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
		sleep_i |=> !fail_reg && !ext_running_reg)
		else $error("sleep clear");

	// The fail condition holds until sleep or a select change.
	AST_FAIL_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
		fail_reg && !sleep_i && !select_change |=> fail_reg)
		else $error("fail dropped");

	// The flag rises only after a detected failure.
	AST_FLAG_RISE: assert property (@(posedge clk_i) disable iff (rst_i)
		!flag_reg ##1 flag_reg |-> $past(fail_event))
		else $error("flag without fail");

	// A crystal mode waits for the full start count.
	AST_TIMER_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
		uses_timer && start_reg != START_COUNT && !ext_running_reg |=> !ext_running_reg)
		else $error("timer skipped");

	// Clock-input and RC modes run at once without the timer.
	AST_NO_TIMER: assert property (@(posedge clk_i) disable iff (rst_i)
		!uses_timer && control_reg[1:0] == SEL_CONFIG && !fail_reg && !sleep_i
		&& !select_change |=> ext_running_reg) else $error("timer used");

	// Code runs on the internal clock while the external one starts.
	AST_INTERNAL_START: assert property (@(posedge clk_i) disable iff (rst_i)
		control_reg[1:0] == SEL_CONFIG && !ext_running_reg |=> clk_source_o == CLK_INTERNAL)
		else $error("not internal");

	// Select 1x always picks the internal block.
	AST_SELECT_INTERNAL: assert property (@(posedge clk_i) disable iff (rst_i)
		control_reg[1] |=> clk_source_o == CLK_INTERNAL)
		else $error("select internal");

	// Select 01 picks the secondary oscillator.
	AST_SELECT_SECONDARY: assert property (@(posedge clk_i) disable iff (rst_i)
		control_reg[1:0] == SEL_SECONDARY |=> clk_source_o == CLK_SECONDARY)
		else $error("select secondary");

	// The fallback frequency always follows the live select field.
	AST_FREQ_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> internal_freq_o == $past(control_reg[6:3]))
		else $error("freq lag");

	// Without the configuration bit the soft bit alone drives the PLL.
	AST_PLL_SOFT: assert property (@(posedge clk_i) disable iff (rst_i)
		!config_i.config_pll_force |=> pll_enable_o == $past(control_reg[BIT_SOFT_PLL]))
		else $error("pll soft");

	// The trim output follows the stored six-bit field.
	AST_TRIM_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> freq_trim_o == $past(trim_reg))
		else $error("trim lag");

	// The two upper trim bits read as zero.
	AST_TRIM_READ: assert property (@(posedge clk_i) disable iff (rst_i)
		adr_i == OFS_TRIM |-> read_mux[7:6] == 2'b00)
		else $error("trim upper bits");

	// The flag pin mirrors the flag one edge later.
	AST_FLAG_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> osc_fail_flag_o == $past(flag_reg))
		else $error("flag pin lag");
endmodule // fail_safe_clock_monitor
`default_nettype wire

// *** ext_osc_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Crystal stand-in: one oscillation every four system clocks while running.
module ext_osc_model (
	// Clock and control.
	input wire logic clk_i,
	input wire logic run_i,
	// Oscillator outputs.
	output logic ext_clk_o,
	output logic tick_o
);
	logic [1:0] phase_reg = 2'h0;

	// A dead crystal sticks high, so no falling edge ever reaches the monitor.
	always_ff @(posedge clk_i)
	begin
		if (run_i)
			phase_reg <= phase_reg + 2'h1;
	end

	// One start tick per full oscillation, only while running.
	assign ext_clk_o = run_i ? phase_reg[1] : 1'b1;
	assign tick_o = run_i && (phase_reg == 2'h1);
endmodule // ext_osc_model
`default_nettype wire

// *** fail_safe_clock_monitor_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module fail_safe_clock_monitor_tb;
	import clock_monitor_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic lf_clk = 1'b0, run = 1'b1, sec_en = 1'b0, ext_clk, tick, ack_o, pll_o, flag_o;
	logic [3:0] adr_i = 4'h0, freq_o;
	logic [31:0] dat_i = 32'h0, dat_o;
	logic [5:0] trim_o;
	logic sleep = 1'b0;
	config_word_t cfg = {MODE_XT, 1'b1, 1'b0};
	logic [7:0] v;
	osc_ready_t rdy = '0;
	clk_source_t src_o;
	int n_mismatch = 0, checked = 0, seed = 32'h8073;
	logic [31:0] exp_q[$];

	ext_osc_model osc (.clk_i(clk_i), .run_i(run), .ext_clk_o(ext_clk), .tick_o(tick));
	fail_safe_clock_monitor uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.ext_clk_i(ext_clk), .lf_osc_clk_i(lf_clk), .ext_start_tick_i(tick), .sleep_i(sleep),
		.secondary_osc_enable_i(sec_en), .ready_i(rdy), .config_i(cfg),
		.clk_source_o(src_o), .internal_freq_o(freq_o), .pll_enable_o(pll_o),
		.freq_trim_o(trim_o), .osc_fail_flag_o(flag_o));

	// System clock and a slow, unrelated low-frequency oscillator.
	always #20 clk_i = ~clk_i;
	always #100 lf_clk = ~lf_clk;

	task automatic test_done;
		if (n_mismatch == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Classic cycle: hold everything until ack is sampled, then release for a cycle.
	task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
		if (n >= 20)
		begin
			n_mismatch++;
			test_done();
		end
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(a, 1'b0, 8'h00);
	endtask

	// Bounded wait for a clock source and fail flag combination.
	task automatic wt(input clk_source_t s, input logic f);
		int n;
		for (n = 0; n < 20000 && !(src_o === s && flag_o === f); n++)
			@(posedge clk_i);
		chk("clk_source_o", 32'(src_o), 32'(s));
		chk("osc_fail_flag_o", 32'(flag_o), 32'(f));
		if (n >= 20000)
		begin
			n_mismatch++;
			test_done();
		end
	endtask

	function automatic logic [7:0] st(input logic e);
		return {sec_en ? rdy.sec_ready : 1'b1, rdy.pll_ready, e, rdy.hf_ready,
			rdy.hf_locked, rdy.mf_ready, rdy.lf_ready, rdy.hf_stable};
	endfunction

	// Read data is compared against the oldest note at each read acknowledge.
	always @(posedge clk_i)
		if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0)
			chk("dat_o", dat_o, exp_q.pop_front());

	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rdy <= osc_ready_t'($random(seed));
		sec_en <= $random(seed);
		@(posedge clk_i);
		@(negedge clk_i);
		chk("clk_source_o", 32'(src_o), 32'(CLK_INTERNAL));
		chk("internal_freq_o", 32'(freq_o), 32'(FREQ_RESET));
		@(posedge clk_i);
		rd(OFS_CONTROL, CONTROL_RESET);
		rd(OFS_FLAGS, 8'h00);
		repeat (3)
		begin
			v = $random(seed);
			bus(OFS_TRIM, 1'b1, v);
			rd(OFS_TRIM, {2'b00, v[5:0]});
			chk("freq_trim_o", 32'(trim_o), 32'(v[5:0]));
		end
		bus(4'h3, 1'b1, 8'hFF);
		rd(4'h3, 8'h00);
		// Select stays 00, so the start timer keeps counting.
		bus(OFS_CONTROL, 1'b1, 8'hF4);
		rd(OFS_CONTROL, 8'hF0);
		chk("pll_enable_o", 32'(pll_o), 32'h1);
		chk("internal_freq_o", 32'(freq_o), 32'(FREQ_PLL_CODE));
		wt(CLK_CONFIG, 1'b0);
		rd(OFS_STATUS, st(1'b1));
		run <= 1'b0;
		wt(CLK_INTERNAL, 1'b1);
		chk("internal_freq_o", 32'(freq_o), 32'(FREQ_PLL_CODE));
		rd(OFS_STATUS, st(1'b0));
		rd(OFS_FLAGS, 8'h01);
		// A revived crystal must not pull the clock back by itself.
		run <= 1'b1;
		repeat (400) @(posedge clk_i);
		chk("clk_source_o", 32'(src_o), 32'(CLK_INTERNAL));
		rd(OFS_FLAGS, 8'h01);
		bus(OFS_FLAGS, 1'b1, 8'h00);
		rd(OFS_FLAGS, 8'h00);
		bus(OFS_CONTROL, 1'b1, 8'hF2);
		bus(OFS_CONTROL, 1'b1, 8'hF0);
		wt(CLK_CONFIG, 1'b0);
		// A second failure after a clean restart sets the cleared flag again.
		run <= 1'b0;
		wt(CLK_INTERNAL, 1'b1);
		// Sleep drops the fail condition, but only software or reset clears the flag.
		sleep <= 1'b1;
		@(posedge clk_i);
		sleep <= 1'b0;
		repeat (400) @(posedge clk_i);
		rd(OFS_STATUS, st(1'b0));
		chk("clk_source_o", 32'(src_o), 32'(CLK_INTERNAL));
		rd(OFS_FLAGS, 8'h01);
		run <= 1'b1;
		wt(CLK_CONFIG, 1'b1);
		// Mid-run reset into a clock-input mode: no start timer, PLL forced on.
		rst_i <= 1'b1;
		cfg <= {3'h4, 1'b1, 1'b1};
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
		chk("osc_fail_flag_o", 32'(flag_o), 32'h0);
		@(posedge clk_i);
		rd(OFS_CONTROL, CONTROL_RESET);
		chk("pll_enable_o", 32'(pll_o), 32'h1);
		wt(CLK_CONFIG, 1'b0);
		rd(OFS_STATUS, st(1'b1));
		test_done();
	end
endmodule // fail_safe_clock_monitor_tb
`default_nettype wire
